// File: inc/ifc_pkg.sv
// constants, register map and state type of the image format control block
package ifc_pkg;
  // register bus
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DECIM = 8'h04;
  localparam logic [7:0] OFS_ROI_START = 8'h08;
  localparam logic [7:0] OFS_ROI_SIZE = 8'h0C;
  localparam logic [7:0] OFS_MAX_DR = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_ARRAY = 8'h18;
  localparam logic [7:0] OFS_MAX_SIZE = 8'h1C;
  localparam logic [7:0] OFS_CUR_DR = 8'h20;
  localparam logic [7:0] OFS_DROP = 8'h24;
  localparam logic [7:0] OFS_RATIO = 8'h28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control register fields
  localparam int CB_RUN = 0;
  localparam int CB_MIRROR_LR = 1;
  localparam int CB_MIRROR_TB = 2;
  localparam int CB_ISP = 3;
  localparam int CB_ADAPT = 4;
  localparam int CB_FR_CTRL = 5;
  localparam int CF_COMP_LSB = 8;
  localparam int CF_ADC_LSB = 12;
  localparam int CF_PAT_LSB = 16;
  localparam int CF_FMT_LSB = 24;
  // skip / merge register fields, 8 bits each
  localparam int DF_CSKIP_LSB = 0;
  localparam int DF_RSKIP_LSB = 8;
  localparam int DF_CMERGE_LSB = 16;
  localparam int DF_RMERGE_LSB = 24;
  // status register fields
  localparam int SB_BUSY = 0;
  localparam int SB_THROTTLE = 1;
  localparam int SB_COMP_ACT = 2;
  localparam int SB_DECIM_ACT = 3;
  localparam int SB_BIN_ACT = 4;
  localparam int SF_PHASE_LSB = 8;
  // reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_DECIM = 32'h0101_0101;
  localparam logic [31:0] RST_ROI_START = 32'h0000_0000;
  localparam logic [31:0] RST_ROI_SIZE = 32'h0BC0_1010;
  localparam logic [31:0] RST_MAX_DR = 32'h0800_0000;
  // array geometry
  localparam logic [15:0] ARRAY_COLS = 16'h1010;
  localparam logic [15:0] ARRAY_ROWS = 16'h0BC0;
  // encodings
  localparam logic [1:0] FMT_MONO8 = 2'h0;
  localparam logic [1:0] FMT_RG8 = 2'h1;
  localparam logic [1:0] FMT_MONO16 = 2'h2;
  localparam logic [1:0] FMT_RG16 = 2'h3;
  localparam logic [1:0] COMP_LOSSLESS = 2'h1;
  localparam logic [2:0] PAT_COL = 3'h1;
  localparam logic [2:0] PAT_ROW = 3'h2;
  localparam logic [2:0] PAT_DIAG = 3'h3;
  localparam logic [2:0] PAT_CHECK = 3'h4;
  // phase: bit0 toggles with left-right, bit1 with top-bottom mirroring
  localparam logic [1:0] PH_RG = 2'h0;
  // fixed encoding table: code length by magnitude class
  localparam logic [4:0] FIX_LEN0 = 5'h04;
  localparam logic [4:0] FIX_LEN1 = 5'h06;
  localparam logic [4:0] FIX_LEN2 = 5'h08;
  localparam logic [4:0] FIX_LEN3 = 5'h0A;
  localparam logic [7:0] FIX_LIM0 = 8'h04;
  localparam logic [7:0] FIX_LIM1 = 8'h10;
  localparam logic [7:0] FIX_LIM2 = 8'h40;
  localparam logic [2:0] ADAPT_K_INIT = 3'h2;
  localparam logic [4:0] ADAPT_LEN_MAX = 5'h10;
  // timing
  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int DR_WINDOW_S = 1;
  localparam int DR_WINDOW_CYCLES = DR_WINDOW_S * CLK_FREQ_HZ;
  localparam logic [5:0] DIV_STEPS = 6'h28;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ISSUE, ST_FETCH, ST_CAPTURE, ST_HOLD, ST_DIV
  } ifc_state_e;
endpackage : ifc_pkg

// File: logic/ifc_image_format.sv
// readout window, mirroring, skipping, test image and compression rate control
`timescale 1ns/1ps
// Summary of operation
// - row skip N keeps one row per N
// - row skip 1 is off; merge needs skips 1
// - column skip 1 is off; else one per N
// - left-right mirror before window; phase toggles
// - top-bottom mirror before window; phase toggles
// - selected synthetic image replaces sensor data
// - lossless only without core, 8-bit mono/RG
// - deeper converter depth slows pixel rate
// - adaptive code tables, else fixed table
// - readable uncompressed to compressed size ratio
// - saturated: drop frames or hold frame start
// - writable byte rate ceiling triggers saturation handling
// - readable current datarate tracker
// - readable count of rate-dropped frames
// - array width reads 4112
// - array height reads 3008
// - max width after merge, window-independent
// - max height after merge, window-independent
// - output width from window width, column skip
// - output height from window height, row skip
// - window begins at configured start row
// - skipping only while both merge factors 1
module ifc_image_format #(
  parameter int unsigned WINDOW_CYCLES = ifc_pkg::DR_WINDOW_CYCLES,
  parameter int SENS_DW = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register bus
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ifc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ifc_pkg::AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // sensor array read port, data one cycle after the request
  output logic sens_req,
  output logic [15:0] sens_col,
  output logic [15:0] sens_row,
  input wire logic [SENS_DW-1:0] sensor_data,
  // pixel stream to the host
  output logic pix_valid,
  input wire logic pix_ready,
  output logic [15:0] pix_data,
  output logic pix_sof,
  output logic pix_eol,
  output logic pix_eof
);
  import ifc_pkg::*;

  if (SENS_DW < 12 || SENS_DW > 16) begin : g_chk_dw
    $error("sensor data width must be 12 to 16");
  end
  if (WINDOW_CYCLES < 2) begin : g_chk_win
    $error("datarate window must be at least two cycles");
  end

  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [31:0] decim;
    logic [31:0] roi_start;
    logic [31:0] roi_size;
    logic [31:0] max_dr;
    ifc_state_e state;
    logic drop;
    logic throttle;
    logic [15:0] col_rel;
    logic [15:0] row_rel;
    logic [1:0] wait_cnt;
    logic sens_req;
    logic [15:0] sens_col;
    logic [15:0] sens_row;
    logic out_valid;
    logic [15:0] out_data;
    logic out_sof;
    logic out_eol;
    logic out_eof;
    logic [7:0] prev_pix;
    logic [2:0] k;
    logic [31:0] raw_bits;
    logic [31:0] comp_bits;
    logic [31:0] win_bits;
    logic [31:0] win_cnt;
    logic [31:0] cur_dr;
    logic [31:0] drop_cnt;
    logic [31:0] ratio;
    logic [5:0] div_cnt;
    logic [39:0] div_num;
    logic [32:0] div_rem;
    logic [31:0] div_den;
    logic [31:0] div_quo;
  } ifc_regs_s;

  ifc_regs_s st;
  ifc_regs_s next_st;

  function automatic logic [31:0] ifc_wmerge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : ifc_wmerge

  // merge factors above four are not supported for the maximum size
  function automatic logic [15:0] ifc_merged(input logic [15:0] full,
      input logic [7:0] f);
    case (f)
      8'h02: return full / 16'h0002;
      8'h03: return full / 16'h0003;
      8'h04: return full / 16'h0004;
      default: return full;
    endcase
  endfunction : ifc_merged

  // configuration views
  logic [7:0] cskip, rskip, cmerge, rmerge;
  logic decim_act, bin_act, comp_act, fmt16;
  logic [15:0] cstep, rstep, roi_w, roi_h, max_cols, max_rows;
  logic [16:0] col_next, row_next;
  logic last_col, last_row, saturated;
  logic [15:0] img_col, img_row;
  logic [1:0] phase, adc_sel, fmt;
  logic [2:0] pat;

  assign cskip = st.decim[DF_CSKIP_LSB +: 8];
  assign rskip = st.decim[DF_RSKIP_LSB +: 8];
  assign cmerge = st.decim[DF_CMERGE_LSB +: 8];
  assign rmerge = st.decim[DF_RMERGE_LSB +: 8];
  assign decim_act = (cmerge <= 8'h01) && (rmerge <= 8'h01);
  assign bin_act = (cskip <= 8'h01) && (rskip <= 8'h01)
                 && ((cmerge > 8'h01) || (rmerge > 8'h01));
  // a factor of 0 or 1 leaves every column and row in place
  assign cstep = (decim_act && cskip > 8'h01) ? {8'h00, cskip} : 16'h0001;
  assign rstep = (decim_act && rskip > 8'h01) ? {8'h00, rskip} : 16'h0001;
  assign roi_w = st.roi_size[15:0];
  assign roi_h = st.roi_size[31:16];
  assign col_next = {1'b0, st.col_rel} + {1'b0, cstep};
  assign row_next = {1'b0, st.row_rel} + {1'b0, rstep};
  assign last_col = col_next >= {1'b0, roi_w};
  assign last_row = row_next >= {1'b0, roi_h};
  // mirrored image coordinates, window placed afterwards
  assign img_col = st.roi_start[15:0] + st.col_rel;
  assign img_row = st.roi_start[31:16] + st.row_rel;
  assign max_cols = ifc_merged(ARRAY_COLS, bin_act ? cmerge : 8'h01);
  assign max_rows = ifc_merged(ARRAY_ROWS, bin_act ? rmerge : 8'h01);
  assign phase = PH_RG ^ {st.ctrl[CB_MIRROR_TB], st.ctrl[CB_MIRROR_LR]};
  assign fmt = st.ctrl[CF_FMT_LSB +: 2];
  assign adc_sel = st.ctrl[CF_ADC_LSB +: 2];
  assign pat = st.ctrl[CF_PAT_LSB +: 3];
  assign fmt16 = (fmt == FMT_MONO16) || (fmt == FMT_RG16);
  assign comp_act = (st.ctrl[CF_COMP_LSB +: 2] == COMP_LOSSLESS)
                  && !st.ctrl[CB_ISP]
                  && ((fmt == FMT_MONO8) || (fmt == FMT_RG8));
  assign saturated = (st.win_bits >> 3) > st.max_dr;

  // per-pixel working values
  logic [11:0] pix12, adc_mask;
  logic [7:0] pix8, mag, prev_use;
  logic [8:0] diff;
  logic [4:0] bpp, fix_len, ad_len, code_len;
  logic [7:0] ad_sum;
  logic [31:0] win_base, win_add;
  logic [32:0] div_t;
  logic wr_ok, rd_ok;
  logic [31:0] rd_val;

  always_comb begin
    next_st = st;
    next_st.sens_req = 1'b0;
    pix12 = 12'h000;
    adc_mask = 12'hFFF;
    pix8 = 8'h00;
    prev_use = 8'h00;
    diff = 9'h000;
    mag = 8'h00;
    bpp = fmt16 ? 5'h10 : 5'h08;
    fix_len = FIX_LEN3;
    ad_len = 5'h00;
    ad_sum = 8'h00;
    code_len = 5'h00;
    win_add = 32'h0000_0000;
    div_t = 33'h0_0000_0000;
    wr_ok = 1'b1;
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_have = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_have && st.w_have && !st.bvalid) begin
      unique case (st.aw_addr)
        OFS_CTRL: next_st.ctrl = ifc_wmerge(st.ctrl, st.wdata, st.wstrb);
        OFS_DECIM: next_st.decim = ifc_wmerge(st.decim, st.wdata, st.wstrb);
        OFS_ROI_START:
          next_st.roi_start = ifc_wmerge(st.roi_start, st.wdata, st.wstrb);
        OFS_ROI_SIZE:
          next_st.roi_size = ifc_wmerge(st.roi_size, st.wdata, st.wstrb);
        OFS_MAX_DR:
          next_st.max_dr = ifc_wmerge(st.max_dr, st.wdata, st.wstrb);
        OFS_STATUS, OFS_ARRAY, OFS_MAX_SIZE, OFS_CUR_DR, OFS_DROP,
        OFS_RATIO: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
    end

    // read channel
    unique case (s_axi_araddr)
      OFS_CTRL: rd_val = st.ctrl;
      OFS_DECIM: rd_val = st.decim;
      OFS_ROI_START: rd_val = st.roi_start;
      OFS_ROI_SIZE: rd_val = st.roi_size;
      OFS_MAX_DR: rd_val = st.max_dr;
      OFS_STATUS: begin
        rd_val[SB_BUSY] = st.state != ST_IDLE;
        rd_val[SB_THROTTLE] = st.throttle;
        rd_val[SB_COMP_ACT] = comp_act;
        rd_val[SB_DECIM_ACT] = decim_act;
        rd_val[SB_BIN_ACT] = bin_act;
        rd_val[SF_PHASE_LSB +: 2] = phase;
      end
      OFS_ARRAY: rd_val = {ARRAY_ROWS, ARRAY_COLS};
      OFS_MAX_SIZE: rd_val = {max_rows, max_cols};
      OFS_CUR_DR: rd_val = st.cur_dr;
      OFS_DROP: rd_val = st.drop_cnt;
      OFS_RATIO: rd_val = st.ratio;
      default: rd_ok = 1'b0;
    endcase
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_val;
      next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // pixel path
    unique case (adc_sel)
      2'h0: adc_mask = 12'hFF0;
      2'h1: adc_mask = 12'hFFC;
      default: adc_mask = 12'hFFF;
    endcase
    if (st.state == ST_CAPTURE) begin
      unique case (pat)
        PAT_COL: pix12 = img_col[11:0];
        PAT_ROW: pix12 = img_row[11:0];
        PAT_DIAG: pix12 = img_col[11:0] + img_row[11:0];
        PAT_CHECK: pix12 = (img_col[3] ^ img_row[3]) ? 12'hFFF : 12'h000;
        default: pix12 = sensor_data[SENS_DW-1 -: 12];
      endcase
      pix12 = pix12 & adc_mask;
      pix8 = pix12[11:4];
      prev_use = (st.col_rel == 16'h0000) ? 8'h00 : st.prev_pix;
      diff = {1'b0, pix8} - {1'b0, prev_use};
      mag = diff[8] ? 8'(~diff[7:0] + 8'h01) : diff[7:0];
      if (mag < FIX_LIM0) begin
        fix_len = FIX_LEN0;
      end else if (mag < FIX_LIM1) begin
        fix_len = FIX_LEN1;
      end else if (mag < FIX_LIM2) begin
        fix_len = FIX_LEN2;
      end
      ad_sum = 8'h01 + {5'h00, st.k} + (mag >> st.k);
      ad_len = (ad_sum > {3'h0, ADAPT_LEN_MAX}) ? ADAPT_LEN_MAX : ad_sum[4:0];
      code_len = !comp_act ? bpp
               : (st.ctrl[CB_ADAPT] ? ad_len : fix_len);
    end

    // datarate window
    win_base = st.win_bits;
    next_st.win_cnt = st.win_cnt + 32'h0000_0001;
    if (st.win_cnt == 32'(WINDOW_CYCLES - 1)) begin
      next_st.win_cnt = 32'h0000_0000;
      next_st.cur_dr = st.win_bits >> 3;
      win_base = 32'h0000_0000;
    end

    unique case (st.state)
      ST_IDLE: begin
        if (st.ctrl[CB_RUN] && roi_w != 16'h0000 && roi_h != 16'h0000) begin
          next_st.throttle = 1'b0;
          if (saturated && !st.ctrl[CB_FR_CTRL]) begin
            next_st.throttle = 1'b1;
          end else begin
            next_st.drop = saturated;
            if (saturated) begin
              next_st.drop_cnt = st.drop_cnt + 32'h0000_0001;
            end
            next_st.col_rel = 16'h0000;
            next_st.row_rel = 16'h0000;
            next_st.raw_bits = 32'h0000_0000;
            next_st.comp_bits = 32'h0000_0000;
            next_st.k = ADAPT_K_INIT;
            next_st.wait_cnt = adc_sel;
            next_st.state = ST_ISSUE;
          end
        end
      end
      ST_ISSUE: begin
        // extra converter time per pixel at deeper bit depth
        if (st.wait_cnt != 2'h0) begin
          next_st.wait_cnt = st.wait_cnt - 2'h1;
        end else begin
          next_st.sens_req = 1'b1;
          next_st.sens_col = st.ctrl[CB_MIRROR_LR]
                           ? ARRAY_COLS - 16'h0001 - img_col : img_col;
          next_st.sens_row = st.ctrl[CB_MIRROR_TB]
                           ? ARRAY_ROWS - 16'h0001 - img_row : img_row;
          next_st.state = ST_FETCH;
        end
      end
      ST_FETCH: next_st.state = ST_CAPTURE;
      ST_CAPTURE: begin
        next_st.out_valid = !st.drop;
        next_st.out_data = fmt16 ? {pix12, 4'h0} : {8'h00, pix8};
        next_st.out_sof = (st.col_rel == 16'h0000)
                        && (st.row_rel == 16'h0000);
        next_st.out_eol = last_col;
        next_st.out_eof = last_col && last_row;
        next_st.prev_pix = pix8;
        if (st.ctrl[CB_ADAPT]) begin
          if (mag > (8'h01 << st.k) && st.k != 3'h7) begin
            next_st.k = st.k + 3'h1;
          end else if (mag < (8'h01 << st.k) >> 1 && st.k != 3'h0) begin
            next_st.k = st.k - 3'h1;
          end
        end
        if (!st.drop) begin
          next_st.raw_bits = st.raw_bits + {27'h0, bpp};
          next_st.comp_bits = st.comp_bits + {27'h0, code_len};
          win_add = {27'h0, code_len};
        end
        next_st.state = ST_HOLD;
      end
      ST_HOLD: begin
        if (!st.out_valid || pix_ready) begin
          next_st.out_valid = 1'b0;
          next_st.wait_cnt = adc_sel;
          next_st.state = ST_ISSUE;
          if (!last_col) begin
            next_st.col_rel = col_next[15:0];
          end else begin
            next_st.col_rel = 16'h0000;
            next_st.row_rel = row_next[15:0];
            if (last_row) begin
              next_st.state = ST_IDLE;
              if (!st.drop && st.comp_bits != 32'h0000_0000) begin
                next_st.div_num = {st.raw_bits, 8'h00};
                next_st.div_den = st.comp_bits;
                next_st.div_rem = 33'h0_0000_0000;
                next_st.div_quo = 32'h0000_0000;
                next_st.div_cnt = DIV_STEPS;
                next_st.state = ST_DIV;
              end
            end
          end
        end
      end
      ST_DIV: begin
        // restoring division, ratio in 24.8 fixed point
        div_t = {st.div_rem[31:0], st.div_num[39]};
        next_st.div_num = {st.div_num[38:0], 1'b0};
        if (div_t >= {1'b0, st.div_den}) begin
          next_st.div_rem = div_t - {1'b0, st.div_den};
          next_st.div_quo = {st.div_quo[30:0], 1'b1};
        end else begin
          next_st.div_rem = div_t;
          next_st.div_quo = {st.div_quo[30:0], 1'b0};
        end
        next_st.div_cnt = st.div_cnt - 6'h01;
        if (st.div_cnt == 6'h01) begin
          next_st.ratio = next_st.div_quo;
          next_st.state = ST_IDLE;
        end
      end
    endcase
    next_st.win_bits = win_base + win_add;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= RST_CTRL;
      st.decim <= RST_DECIM;
      st.roi_start <= RST_ROI_START;
      st.roi_size <= RST_ROI_SIZE;
      st.max_dr <= RST_MAX_DR;
      st.state <= ST_IDLE;
      st.k <= ADAPT_K_INIT;
    end else begin
      st <= next_st;
    end
  end

  // a pending response holds off the next request on that channel
  assign s_axi_awready = !st.aw_have && !st.bvalid;
  assign s_axi_wready = !st.w_have && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign sens_req = st.sens_req;
  assign sens_col = st.sens_col;
  assign sens_row = st.sens_row;
  assign pix_valid = st.out_valid;
  assign pix_data = st.out_data;
  assign pix_sof = st.out_sof;
  assign pix_eol = st.out_eol;
  assign pix_eof = st.out_eof;
endmodule : ifc_image_format

// File: bench/ifc_checker_props.sv
// port-level checks of the image format control block
`timescale 1ns/1ps
module ifc_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sensor port and pixel stream
  input wire logic sens_req,
  input wire logic [15:0] sens_col,
  input wire logic [15:0] sens_row,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic [15:0] pix_data
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_idle_gap;
    !sens_req ##1 !sens_req;
  endsequence
  a_write_lat: assert property (s_both_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_write_refused: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not cleared");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_clear: assert property
    (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not cleared");
  a_sens_gap: assert property (sens_req |=> s_idle_gap)
    else $error("sensor reads too close");
  a_pix_hold: assert property
    (pix_valid && !pix_ready |=> pix_valid && $stable(pix_data))
    else $error("pixel dropped while stalled");
  a_addr_hold: assert property
    (s_idle_gap |-> $stable({sens_col, sens_row}))
    else $error("sensor address moved without read");
endmodule : ifc_checker
bind ifc_image_format ifc_checker ifc_checker_inst (.*);

// File: bench/ifc_host_model.sv
// sensor array answering reads and a pixel sink that stalls
`timescale 1ns/1ps
module ifc_host_model (
  // clock
  input wire logic clock,
  // sensor array read port
  input wire logic sens_req,
  input wire logic [15:0] sens_col,
  input wire logic [15:0] sens_row,
  output logic [11:0] sensor_data,
  // pixel stream
  output logic pix_ready
);
  always @(posedge clock) begin
    pix_ready <= ($urandom % 3) != 0;
    // toggles outside the answer cycle so a late sample cannot look right
    sensor_data <= sens_req ? sens_col[11:0] + {sens_row[5:0], 6'h00}
                            : ~sensor_data;
  end
endmodule : ifc_host_model

// File: bench/test_image_format_control.sv
// self-checking bench for the image format control block
`timescale 1ns/1ps
module test_image_format_control;
  import ifc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sens_req, pix_valid, pix_ready;
  logic pix_sof, pix_eol, pix_eof;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, q;
  logic [15:0] sens_col, sens_row, pix_data;
  logic [11:0] sensor_data;
  int fail_count = 0, tests_run = 0;
  int w, h, c0, r0, ck, rk, lr, tb;
  always #4 clock = ~clock;
  ifc_image_format #(.WINDOW_CYCLES(200)) ifc_image_format_inst (.*);
  ifc_host_model ifc_host_model_inst (.*);
  task automatic summarize();
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stuck();
    fail_count++;
    $display("MISMATCH %0t wait ran out", $time);
    summarize();
  endtask : stuck
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    bit done;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      // handshakes and the answer are taken at the rising edge itself
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      n++;
    end while (!done && n < 100);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!done) stuck();
    @(posedge clock);
  endtask : axi
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    axi(0, a, 0);
    chk(q, e);
  endtask : rdc
  function automatic logic [11:0] pv(input logic [15:0] c, input logic [15:0] y);
    return c[11:0] + {y[5:0], 6'h00};
  endfunction : pv
  task automatic frame();
    int n = 0, t = 0;
    int nw = (w + ck - 1) / ck;
    int nh = (h + rk - 1) / rk;
    logic [15:0] c, y;
    logic [2:0] e;
    while (n < nw * nh && t < 4000) begin
      @(negedge clock);
      t++;
      if (pix_valid && pix_ready && (n > 0 || pix_sof)) begin
        c = 16'(c0 + n % nw * ck);
        y = 16'(r0 + n / nw * rk);
        if (lr) c = 16'd4111 - c;
        if (tb) y = 16'd3007 - y;
        e = {n == 0, n % nw == nw - 1, n == nw * nh - 1};
        chk(pix_data, {pv(c, y), 4'h0});
        chk({pix_sof, pix_eol, pix_eof}, e);
        n++;
      end
    end
    if (t >= 4000) stuck();
  endtask : frame
  task automatic halt();
    int n = 0;
    axi(1, OFS_CTRL, 32'h0);
    do begin
      axi(0, OFS_STATUS, 0);
      n++;
    end while (q[SB_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) stuck();
  endtask : halt
  initial begin
    int n;
    void'($urandom(54206));
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdc(OFS_CTRL, RST_CTRL);
    rdc(OFS_DECIM, RST_DECIM);
    rdc(OFS_MAX_DR, RST_MAX_DR);
    axi(1, OFS_ARRAY, 0);
    rdc(OFS_ARRAY, 32'h0BC0_1010);
    axi(1, 8'h30, 32'h1);
    chk(r, RESP_SLVERR);
    axi(0, 8'h30, 0);
    chk(r, RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      axi(1, OFS_CTRL, {6'h00, i[1:0], 14'h0, 2'h1, 4'h0, i[2], i[1:0], 1'b0});
      axi(0, OFS_STATUS, 0);
      chk({q[9:8], q[2]}, {i[1:0], !i[2] && i[1:0] < 2});
    end
    axi(1, OFS_DECIM, 32'h0202_0101);
    rdc(OFS_MAX_SIZE, {16'd1504, 16'd2056});
    axi(0, OFS_STATUS, 0);
    chk(q[4:3], 2'b10);
    for (int i = 0; i < 5; i++) begin
      w = 1 + $urandom % 7;
      h = 1 + $urandom % 4;
      ck = 1 + $urandom % 3;
      rk = 1 + $urandom % 3;
      // window kept inside the array, last pass hugs the far corner
      c0 = (i == 4) ? 4112 - w : $urandom % (4112 - w);
      r0 = (i == 4) ? 3008 - h : $urandom % (3008 - h);
      lr = i % 2;
      tb = i / 2 % 2;
      axi(1, OFS_DECIM, {16'h0101, 8'(rk), 8'(ck)});
      axi(1, OFS_ROI_START, {16'(r0), 16'(c0)});
      axi(1, OFS_ROI_SIZE, {16'(h), 16'(w)});
      rdc(OFS_MAX_SIZE, 32'h0BC0_1010);
      axi(1, OFS_CTRL, 32'h0200_2001 | (lr << 1) | (tb << 2));
      frame();
      halt();
    end
    axi(1, OFS_MAX_DR, 32'h0);
    axi(1, OFS_CTRL, 32'h0200_2021);
    n = 0;
    do begin
      axi(0, OFS_DROP, 0);
      n++;
    end while (q === 32'h0 && n < 300);
    chk(q != 0, 1);
    axi(0, OFS_CUR_DR, 0);
    chk(q != 0, 1);
    halt();
    summarize();
  end
endmodule : test_image_format_control
